//--- logic/cfo_map.svh
// constants of the clock fanout serial configuration block
// assumes inclusion by bare name from the package and the design modules
`ifndef CFO_MAP_SVH
`define CFO_MAP_SVH

// configuration word layout
`define CFO_WORD_W        11
`define CFO_NUM_OUT       10
`define CFO_SEL_BIT       10
`define CFO_EN_MSB        9
`define CFO_EN_LSB        0

// control register value after clear
`define CFO_CTRL_RESET    11'h000

// shift-clock pulses in one programming sequence
`define CFO_SEQ_PULSES    12

// synchroniser depth in the reference clock domain
`define CFO_SYNC_STAGES   2

`endif

//--- logic/cfo_pkg.sv
// types shared by the clock fanout serial configuration modules
// assumes cfo_map.svh on the include path
`include "cfo_map.svh"

package cfo_pkg;

	typedef logic [`CFO_WORD_W-1:0] cfo_word_t;

	typedef enum logic [0:0]
	{
		CFO_SHIFTING,
		CFO_LOADED
	} cfo_link_state_e;

endpackage

//--- logic/cfo_cfg_if.sv
// carrier between the shift-clock logic and the reference-clock logic
// assumes the word is only sampled after its toggle has been synchronised
`timescale 1ns/1ps
`default_nettype none

interface cfo_cfg_if;
	cfo_pkg::cfo_word_t word;      // loaded configuration word
	logic               load_tgl;  // flips once per completed sequence

	modport link
	(
		output word,
		output load_tgl
	);

	modport ctrl
	(
		input  word,
		input  load_tgl
	);
endinterface

`default_nettype wire

//--- logic/cfo_shift_link.sv
// shift register and sequence counter on the programming shift clock
// assumes link_rst_n is low whenever programming enable is low
`timescale 1ns/1ps
`default_nettype none
`include "cfo_map.svh"

module cfo_shift_link #(
	parameter int WORD_W = `CFO_WORD_W
) (
	input  wire logic   program_shift_clock, // link clock, rising edge shifts
	input  wire logic   link_rst_n,          // async, low while enable low
	input  wire logic   serial_data,         // serial data level
	cfo_cfg_if.link     cfg                  // word and load toggle out
);

	localparam logic [3:0] LOAD_AT = 4'(`CFO_SEQ_PULSES - 1);

	if (WORD_W != `CFO_SEQ_PULSES - 1 || WORD_W > 15)
		$error("cfo_shift_link: word width must be one less than the pulse count");

	// ------------------------------------------------------------
	// word ordering
	// ------------------------------------------------------------
	// first bit sent ends in the last stage, so reverse into word order
	function automatic cfo_pkg::cfo_word_t stage_to_word(input cfo_pkg::cfo_word_t s);
		cfo_pkg::cfo_word_t w;
		w = '0;
		for (int k = 0; k < WORD_W; k++)
			w[k] = s[WORD_W-1-k];
		return w;
	endfunction

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	cfo_pkg::cfo_link_state_e state_r, state_nxt;
	logic [3:0]               cnt_r, cnt_nxt;
	cfo_pkg::cfo_word_t       sr_r, sr_nxt;
	cfo_pkg::cfo_word_t       word_r, word_nxt;
	logic                     tgl_r, tgl_nxt;

	always_comb
	begin
		state_nxt = state_r;
		cnt_nxt   = cnt_r;
		sr_nxt    = sr_r;
		word_nxt  = word_r;
		tgl_nxt   = tgl_r;
		case (state_r)
			cfo_pkg::CFO_SHIFTING:
			begin
				if (cnt_r == LOAD_AT)
				begin
					word_nxt  = stage_to_word(sr_r);
					tgl_nxt   = ~tgl_r;
					state_nxt = cfo_pkg::CFO_LOADED;
				end
				else
				begin
					sr_nxt  = {sr_r[WORD_W-2:0], serial_data};
					cnt_nxt = cnt_r + 4'h1;
				end
			end
			cfo_pkg::CFO_LOADED:
				state_nxt = cfo_pkg::CFO_LOADED;
			default:
				state_nxt = cfo_pkg::CFO_SHIFTING;
		endcase
	end

	// held in reset by a low enable, released fresh by its rising edge
	always_ff @(posedge program_shift_clock or negedge link_rst_n)
	begin
		if (!link_rst_n)
		begin
			state_r <= cfo_pkg::CFO_SHIFTING;
			cnt_r   <= 4'h0;
			sr_r    <= `CFO_CTRL_RESET;
			word_r  <= `CFO_CTRL_RESET;
			tgl_r   <= 1'b0;
		end
		else
		begin
			state_r <= state_nxt;
			cnt_r   <= cnt_nxt;
			sr_r    <= sr_nxt;
			word_r  <= word_nxt;
			tgl_r   <= tgl_nxt;
		end
	end

	assign cfg.word     = word_r;
	assign cfg.load_tgl = tgl_r;

endmodule

`default_nettype wire

//--- logic/cfo_fanout_mux.sv
// input multiplexer and output drivers of the fanout
// assumes sel and enables are steady flops of the reference domain
`timescale 1ns/1ps
`default_nettype none

module cfo_fanout_mux #(
	parameter int N_OUT = 10
) (
	input  wire logic             sel,       // 0 first input, 1 second
	input  wire logic [N_OUT-1:0] enable,    // per output enable
	input  wire logic             in0_p,     // first input, true leg
	input  wire logic             in0_n,     // first input, complement leg
	input  wire logic             in1_p,     // second input, true leg
	input  wire logic             in1_n,     // second input, complement leg
	output logic      [N_OUT-1:0] q_p,       // noninverted outputs
	output logic      [N_OUT-1:0] q_n        // inverted outputs
);

	if (N_OUT < 1)
		$error("cfo_fanout_mux: at least one output");

	logic level0;
	logic level1;
	logic level;

	// open input reads as both legs equal, which gives a low true output
	assign level0 = in0_p & ~in0_n;
	assign level1 = in1_p & ~in1_n;
	assign level  = sel ? level1 : level0;

	// ------------------------------------------------------------
	// drivers
	// ------------------------------------------------------------
	for (genvar i = 0; i < N_OUT; i++)
	begin : g_drv
		// disabled pair idles with both legs low
		assign q_p[i] = enable[i] & level;
		assign q_n[i] = enable[i] & ~level;
	end

endmodule

`default_nettype wire

//--- logic/cfo_clock_fanout.sv
// top of the clock fanout serial configuration block
// assumes ref_clk free running; shift clock and pins unrelated to it
//
// Notes on behaviour
// - while enable is high the first eleven rising shift-clock edges capture the serial data line.
// - the twelfth shift-clock pulse moves the shift register into the control register.
// - a rising enable clears the control register and starts a fresh twelve-pulse sequence.
// - with enable low all ten outputs are on and the serial data level picks the input.
// - with enable low the sequencer, control register and shift register are held in reset.
// - each captured edge loads serial data into the first stage and shifts the rest along.
// - word bit 10 picks the input and bits 9 down to 0 enable outputs 0 through 9.
// - the chosen differential input drives all enabled outputs, an open input reads low.
`timescale 1ns/1ps
`default_nettype none
`include "cfo_map.svh"

module cfo_clock_fanout #(
	parameter int N_OUT = `CFO_NUM_OUT
) (
	input  wire logic             ref_clk,                  // 50 MHz block clock
	input  wire logic             resetn,                   // async, active low
	input  wire logic             program_shift_clock,      // link clock pin
	input  wire logic             serial_data_in,           // serial data pin
	input  wire logic             program_enable,           // programming enable pin
	input  wire logic             first_diff_clock_input_p, // first input, true
	input  wire logic             first_diff_clock_input_n, // first input, complement
	input  wire logic             second_diff_clock_input_p,// second input, true
	input  wire logic             second_diff_clock_input_n,// second input, complement
	output logic      [N_OUT-1:0] fanout_outputs_p,         // noninverted outputs
	output logic      [N_OUT-1:0] fanout_outputs_n,         // inverted outputs
	output logic      [N_OUT-1:0] fanout_enable,            // output enables, flops
	output logic                  input_select,             // chosen input, flop
	output logic                  config_loaded,            // word taken, flop
	output logic                  programming_mode          // synced enable, flop
);

	if (N_OUT != `CFO_NUM_OUT)
		$error("cfo_clock_fanout: output count fixed by the word layout");

	localparam int SYNC_N = `CFO_SYNC_STAGES;

	// ------------------------------------------------------------
	// link side
	// ------------------------------------------------------------
	cfo_cfg_if cfg ();

	logic link_rst_n;

	// enable low holds the link logic in reset whatever the shift clock does
	assign link_rst_n = resetn & program_enable;

	cfo_shift_link #(
		.WORD_W (`CFO_WORD_W)
	) u_link (
		.program_shift_clock (program_shift_clock),
		.link_rst_n          (link_rst_n),
		.serial_data         (serial_data_in),
		.cfg                 (cfg.link)
	);

	// ------------------------------------------------------------
	// crossing into the reference clock domain
	// ------------------------------------------------------------
	// bit 0 enable, bit 1 serial data level, bit 2 load toggle
	localparam int N_SYNC = 3;

	logic [N_SYNC-1:0] sync_in;
	logic [N_SYNC-1:0] sync_out;

	assign sync_in = {cfg.load_tgl, serial_data_in, program_enable};

	for (genvar s = 0; s < N_SYNC; s++)
	begin : g_sync
		logic [SYNC_N-1:0] stg_r;
		logic [SYNC_N-1:0] stg_nxt;

		always_comb
		begin
			stg_nxt = {stg_r[SYNC_N-2:0], sync_in[s]};
		end

		always_ff @(posedge ref_clk or negedge resetn)
		begin
			if (!resetn)
				stg_r <= '0;
			else
				stg_r <= stg_nxt;
		end

		assign sync_out[s] = stg_r[SYNC_N-1];
	end

	logic en_s;
	logic si_s;
	logic tgl_s;

	assign en_s  = sync_out[0];
	assign si_s  = sync_out[1];
	assign tgl_s = sync_out[2];

	// ------------------------------------------------------------
	// word decode
	// ------------------------------------------------------------
	// word bit 9-i enables output i
	function automatic logic [N_OUT-1:0] word_enables(input cfo_pkg::cfo_word_t w);
		logic [N_OUT-1:0] e;
		e = '0;
		for (int i = 0; i < N_OUT; i++)
			e[i] = w[`CFO_EN_MSB-i];
		return e;
	endfunction

	// ------------------------------------------------------------
	// control register
	// ------------------------------------------------------------
	// the word is steady by the time the toggle is seen, because the link
	// side stops shifting once loaded; a toggle flipped back by a link
	// reset may capture a zero word, which equals the cleared value
	cfo_pkg::cfo_word_t ctrl_r, ctrl_nxt;
	logic               en_d_r, en_d_nxt;
	logic               tgl_d_r, tgl_d_nxt;
	logic               loaded_r, loaded_nxt;
	logic               en_rise;
	logic               take_word;

	assign en_rise   = en_s & ~en_d_r;
	assign take_word = en_s & (tgl_s ^ tgl_d_r);

	always_comb
	begin
		en_d_nxt   = en_s;
		tgl_d_nxt  = tgl_s;
		ctrl_nxt   = ctrl_r;
		loaded_nxt = loaded_r;
		if (!en_s)
		begin
			ctrl_nxt   = `CFO_CTRL_RESET;
			loaded_nxt = 1'b0;
		end
		else if (take_word)
		begin
			// a load wins over a clear seen in the same cycle
			ctrl_nxt   = cfg.word;
			loaded_nxt = 1'b1;
		end
		else if (en_rise)
		begin
			ctrl_nxt   = `CFO_CTRL_RESET;
			loaded_nxt = 1'b0;
		end
	end

	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			ctrl_r   <= `CFO_CTRL_RESET;
			en_d_r   <= 1'b0;
			tgl_d_r  <= 1'b0;
			loaded_r <= 1'b0;
		end
		else
		begin
			ctrl_r   <= ctrl_nxt;
			en_d_r   <= en_d_nxt;
			tgl_d_r  <= tgl_d_nxt;
			loaded_r <= loaded_nxt;
		end
	end

	// ------------------------------------------------------------
	// operating mode
	// ------------------------------------------------------------
	// outputs stay off while a sequence is in progress, since the
	// cleared control register disables them all
	logic [N_OUT-1:0] oe_r, oe_nxt;
	logic             sel_r, sel_nxt;
	logic             mode_r, mode_nxt;

	always_comb
	begin
		mode_nxt = en_s;
		if (!en_s)
		begin
			oe_nxt  = '1;
			sel_nxt = si_s;
		end
		else
		begin
			oe_nxt  = word_enables(ctrl_r);
			sel_nxt = ctrl_r[`CFO_SEL_BIT];
		end
	end

	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			oe_r   <= '1;
			sel_r  <= 1'b0;
			mode_r <= 1'b0;
		end
		else
		begin
			oe_r   <= oe_nxt;
			sel_r  <= sel_nxt;
			mode_r <= mode_nxt;
		end
	end

	// ------------------------------------------------------------
	// fanout path
	// ------------------------------------------------------------
	// the clock path itself is combinational; only its steering is flopped
	cfo_fanout_mux #(
		.N_OUT (N_OUT)
	) u_mux (
		.sel    (sel_r),
		.enable (oe_r),
		.in0_p  (first_diff_clock_input_p),
		.in0_n  (first_diff_clock_input_n),
		.in1_p  (second_diff_clock_input_p),
		.in1_n  (second_diff_clock_input_n),
		.q_p    (fanout_outputs_p),
		.q_n    (fanout_outputs_n)
	);

	assign fanout_enable    = oe_r;
	assign input_select     = sel_r;
	assign config_loaded    = loaded_r;
	assign programming_mode = mode_r;

endmodule

`default_nettype wire

//--- testbench/cfo_sva.sv
// assertions on the ports of the fanout configuration top
// assumes a bind from the bench; one clock domain seen, ref_clk
`timescale 1ns/1ps
`default_nettype none
module cfo_sva #(
	parameter int N_OUT = 10
) (
	input wire logic             ref_clk,                   // clock
	input wire logic             resetn,                    // reset
	input wire logic             serial_data_in,            // data pin
	input wire logic             program_enable,            // enable pin
	input wire logic             first_diff_clock_input_p,  // in0 p
	input wire logic             first_diff_clock_input_n,  // in0 n
	input wire logic             second_diff_clock_input_p, // in1 p
	input wire logic             second_diff_clock_input_n, // in1 n
	input wire logic [N_OUT-1:0] fanout_outputs_p,          // true legs
	input wire logic [N_OUT-1:0] fanout_outputs_n,          // comp legs
	input wire logic [N_OUT-1:0] fanout_enable,             // enables
	input wire logic             input_select,              // select
	input wire logic             config_loaded,             // loaded
	input wire logic             programming_mode           // synced enable
);
	// ------------------------------
	// properties
	// ------------------------------
	// open input has p equal n, so it reads low
	wire logic lvl = input_select ?
		(second_diff_clock_input_p & ~second_diff_clock_input_n) :
		(first_diff_clock_input_p & ~first_diff_clock_input_n);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!resetn);
	chk_reset_values: assert property ($rose(resetn) |->
		&fanout_enable && !input_select && !config_loaded) else $error("reset values");
	chk_mode_sync: assert property ($past(resetn, 3) |->
		programming_mode == $past(program_enable, 3)) else $error("mode sync");
	chk_default_on: assert property ((!programming_mode)[*4] |->
		&fanout_enable && !config_loaded) else $error("default enables");
	chk_default_sel: assert property ((!programming_mode && $stable(serial_data_in))[*5]
		|-> input_select == serial_data_in) else $error("default select");
	chk_busy_cleared: assert property ((programming_mode && !config_loaded)[*3]
		|-> fanout_enable == '0 && !input_select) else $error("not cleared");
	chk_loaded_hold: assert property (programming_mode && config_loaded
		&& $past(config_loaded) |=> $stable(fanout_enable) && $stable(input_select)
		|| !config_loaded) else $error("word changed");
	chk_true_leg: assert property (fanout_outputs_p ==
		(fanout_enable & {N_OUT{lvl}})) else $error("true leg");
	chk_comp_leg: assert property (fanout_outputs_n ==
		(fanout_enable & {N_OUT{!lvl}})) else $error("comp leg");
endmodule
`default_nettype wire

//--- testbench/cfo_ctl_model.sv
// controller model driving the serial programming pins
// assumes ref_clk only to time the enable; shift clock idles high
`timescale 1ns/1ps
`default_nettype none
module cfo_ctl_model (
	input  wire logic ref_clk, // block clock
	output var logic  sck,     // shift clock
	output var logic  sdi,     // serial data
	output var logic  en       // programming enable
);
	// ------------------------------
	// frames
	// ------------------------------
	initial
	begin
		sck = 1'b1;
		sdi = 1'b0;
		en  = 1'b0;
	end
	// pulses past the eleventh carry junk on purpose
	task automatic frame(input logic [10:0] w, input int n);
		@(posedge ref_clk);
		en <= 1'b1;
		repeat (8) @(posedge ref_clk);
		#3;
		for (int k = 0; k < n; k++)
		begin
			sck = 1'b0;
			sdi = (k < 11) ? w[k] : ~w[10];
			#80 sck = 1'b1;
			#80;
		end
		sdi = 1'b0; // released, pull-down
	endtask
	task automatic dflt(input logic lv);
		@(posedge ref_clk);
		en  <= 1'b0;
		sdi <= lv;
	endtask
endmodule
`default_nettype wire

//--- testbench/testbench.sv
// self-checking bench of the fanout configuration top
// assumes cfo_ctl_model on the programming pins
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic        ref_clk = 1'b0;
	logic        resetn  = 1'b0;
	logic        f_p     = 1'b1;
	logic        f_n     = 1'b0;
	logic        s_p     = 1'b0;
	logic        s_n     = 1'b1;
	wire logic   sck, sdi, en, sel, loaded, pmode;
	wire logic [9:0] q_p, q_n, fen;
	int          num_errors  = 0;
	int          check_count = 0;
	logic [10:0] words [2] = '{11'h5A3, 11'h0C6};
	logic [9:0]  e;
	// ------------------------------
	// instances and tasks
	// ------------------------------
	cfo_clock_fanout dut_u (.ref_clk(ref_clk), .resetn(resetn),
		.program_shift_clock(sck), .serial_data_in(sdi), .program_enable(en),
		.first_diff_clock_input_p(f_p), .first_diff_clock_input_n(f_n),
		.second_diff_clock_input_p(s_p), .second_diff_clock_input_n(s_n),
		.fanout_outputs_p(q_p), .fanout_outputs_n(q_n), .fanout_enable(fen),
		.input_select(sel), .config_loaded(loaded), .programming_mode(pmode));
	cfo_ctl_model ctl_u (.ref_clk(ref_clk), .sck(sck), .sdi(sdi), .en(en));
	initial
		forever #10 ref_clk = ~ref_clk;
	task automatic check(input logic [9:0] seen, input logic [9:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("MISMATCH at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask
	task automatic results;
		$display("checks %0d errors %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic chk_out(input logic [9:0] en_x, input logic lv);
		// look mid-cycle, away from the edge that launches the flops
		@(negedge ref_clk);
		check(fen, en_x);
		check(q_p, en_x & {10{lv}});
		check(q_n, en_x & {10{~lv}});
	endtask
	task automatic wait_loaded;
		int i;
		for (i = 0; i < 60 && loaded !== 1'b1; i++)
			@(posedge ref_clk);
		if (i == 60)
		begin
			num_errors++;
			$display("MISMATCH at %0t: no load", $time);
			results();
		end
		repeat (3) @(posedge ref_clk);
	endtask
	initial
	begin
		repeat (12) @(posedge ref_clk);
		resetn <= 1'b1;
		@(posedge ref_clk);
		chk_out(10'h3FF, 1'b1);
		for (int lv = 0; lv < 2; lv++)
		begin
			ctl_u.dflt(lv[0]);
			repeat (6) @(posedge ref_clk);
			chk_out(10'h3FF, ~lv[0]);
			check({9'h000, sel}, {9'h000, lv[0]});
		end
		ctl_u.dflt(1'b0);
		f_p <= 1'b0;
		repeat (6) @(posedge ref_clk);
		chk_out(10'h3FF, 1'b0);
		f_p <= 1'b1;
		$display("default mode test done");
		for (int t = 0; t < 2; t++)
		begin
			ctl_u.frame(words[t], 11);
			repeat (8) @(posedge ref_clk);
			check({9'h000, loaded}, 10'h000);
			chk_out(10'h000, 1'b1);
			ctl_u.dflt(1'b0);
			repeat (4) @(posedge ref_clk);
			ctl_u.frame(words[t], 12);
			wait_loaded();
			for (int i = 0; i < 10; i++)
				e[i] = words[t][9 - i];
			chk_out(e, ~words[t][10]);
			check({9'h000, sel}, {9'h000, words[t][10]});
			ctl_u.frame(~words[t], 6);
			repeat (6) @(posedge ref_clk);
			chk_out(e, ~words[t][10]);
			ctl_u.dflt(1'b0);
			repeat (6) @(posedge ref_clk);
			chk_out(10'h3FF, 1'b1);
			$display("program test %0d done", t);
		end
		results();
	end
endmodule
bind cfo_clock_fanout cfo_sva #(.N_OUT(N_OUT)) chk_u (.ref_clk(ref_clk), .resetn(resetn),
	.serial_data_in(serial_data_in), .program_enable(program_enable),
	.first_diff_clock_input_p(first_diff_clock_input_p),
	.first_diff_clock_input_n(first_diff_clock_input_n),
	.second_diff_clock_input_p(second_diff_clock_input_p),
	.second_diff_clock_input_n(second_diff_clock_input_n),
	.fanout_outputs_p(fanout_outputs_p), .fanout_outputs_n(fanout_outputs_n),
	.fanout_enable(fanout_enable), .input_select(input_select),
	.config_loaded(config_loaded), .programming_mode(programming_mode));
`default_nettype wire
